//--- design/ctdc_pkg.sv
// Constants and types for the channel 4 trim and signal-path config block
// Function
// - Channel 4 gain trim is at index 0x4E, resets to 0x80, code in 7-4.
// - Gain code steps 0.1 dB: 0 is -0.8 dB, 8 is 0 dB, 15 is +0.7 dB.
// - Channel 4 phase trim is at index 0x4F, resets to 0x00, all bits RW.
// - Channel 4 bits are delayed by phase-code modulator cycles.
// - Phase codes span the full 8-bit range, up to 255 modulator cycles.
// - Config 0 is at index 0x6B, resets to 0x01, fields 5-4, 3-2, 1-0.
// - Decimation field: 0 linear, 1 low latency, 2 ultra-low, 3 reserved.
// - Summation field 1 outputs the mean of channels 1 and 2; 0 disables it.
// - High-pass field: 0 programmable IIR, 1 to 3 fixed cutoffs, reset 1.
package ctdc_pkg;
   localparam int ADDR_W = 12;
   localparam int SAMPLE_W = 24;
   localparam int GAIN_FRAC = 15;
   localparam int PHASE_DEPTH = 255;
   localparam int MOD_DIV = 64;
   // Register indices; byte address is four times the index
   localparam logic [7:0] GAIN_TRIM_IDX = 8'h4e;
   localparam logic [7:0] PHASE_TRIM_IDX = 8'h4f;
   localparam logic [7:0] PATH_CFG0_IDX = 8'h6b;
   localparam logic [11:0] GAIN_TRIM_ADDR = {2'h0, GAIN_TRIM_IDX, 2'h0};
   localparam logic [11:0] PHASE_TRIM_ADDR = {2'h0, PHASE_TRIM_IDX, 2'h0};
   localparam logic [11:0] PATH_CFG0_ADDR = {2'h0, PATH_CFG0_IDX, 2'h0};
   // Reset values
   localparam logic [7:0] GAIN_TRIM_RST = 8'h80;
   localparam logic [7:0] PHASE_TRIM_RST = 8'h00;
   localparam logic [7:0] PATH_CFG0_RST = 8'h01;
   // Field positions and codes
   localparam int GAIN_CODE_LSB = 4;
   localparam int DECI_LSB = 4;
   localparam int SUM_LSB = 2;
   localparam int HPF_LSB = 0;
   localparam logic [3:0] GAIN_UNITY_CODE = 4'h8;
   localparam logic [1:0] SUM_AVG12 = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Gain factors in Q2.15, -0.8 dB to +0.7 dB in 0.1 dB steps
   localparam logic [16:0] GAIN_LUT [16] = '{
      17'h074bd, 17'h07617, 17'h07775, 17'h078d7,
      17'h07a3d, 17'h07ba8, 17'h07d16, 17'h07e89,
      17'h08000, 17'h0817c, 17'h082fb, 17'h08480,
      17'h08609, 17'h08796, 17'h08928, 17'h08abe};

   typedef enum logic [1:0] {SEL_NONE, SEL_GAIN, SEL_PHASE, SEL_DSP}
      ctdc_sel_t;

   // Byte address to register select
   function automatic ctdc_sel_t decodeAddr(input logic [11:0] addr);
      if (addr == GAIN_TRIM_ADDR) begin
         return SEL_GAIN;
      end else if (addr == PHASE_TRIM_ADDR) begin
         return SEL_PHASE;
      end else if (addr == PATH_CFG0_ADDR) begin
         return SEL_DSP;
      end else begin
         return SEL_NONE;
      end
   endfunction
endpackage

//--- design/ctdc_delay_if.sv
// Link between the register block and the channel 4 phase delay line
`timescale 1ns/10ps
interface ctdc_delay_if;
   logic modEn;
   logic [7:0] code;
   logic bitIn;
   logic bitOut;
   modport source(output modEn, output code, output bitIn, input bitOut);
   modport sink(input modEn, input code, input bitIn, output bitOut);
endinterface

//--- design/ctdc_phase_delay.sv
// Channel 4 modulator-rate delay line steered by the phase code
`timescale 1ns/10ps
module ctdc_phase_delay #(
   parameter int DEPTH = ctdc_pkg::PHASE_DEPTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   ctdc_delay_if.sink dl
);
   typedef struct packed {
      logic [DEPTH-1:0] line;
      logic outBit;
   } ctdc_dly_state_t;

   ctdc_dly_state_t q_reg;
   ctdc_dly_state_t q_next;

   // Shift one bit per modulator cycle, tap at code minus one; code 0 takes the input bit
   always_comb begin
      q_next = q_reg;
      if (dl.modEn) begin
         q_next.line = {q_reg.line[DEPTH-2:0], dl.bitIn};
         if (dl.code == 8'h00) begin
            q_next.outBit = dl.bitIn;
         end else begin
            q_next.outBit = q_reg.line[dl.code - 8'h01];
         end
      end
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign dl.bitOut = q_reg.outBit;

   property p_zero_delay;
      @(posedge clk) disable iff (sys_rst)
      dl.modEn && dl.code == 8'h00 |=> q_reg.outBit == $past(dl.bitIn);
   endproperty
   a_zero_delay: assert property (p_zero_delay)
      else $error("code 0 did not pass the bit straight");

   property p_max_delay;
      @(posedge clk) disable iff (sys_rst)
      dl.modEn && dl.code == 8'hff |=> q_reg.outBit == $past(q_reg.line[254]);
   endproperty
   a_max_delay: assert property (p_max_delay)
      else $error("code 255 tap wrong");
endmodule

//--- design/ctdc_trim_top.sv
// Channel 4 trim and signal-path config registers with AXI4-Lite access
`timescale 1ns/10ps
module ctdc_trim_top #(
   parameter int MOD_DIV = ctdc_pkg::MOD_DIV
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pdmCh4In,
   output logic ch4PdmDelayed,
   output logic modClkEn,
   input wire logic sampleValid,
   input wire logic signed [23:0] ch1Sample,
   input wire logic signed [23:0] ch2Sample,
   input wire logic signed [23:0] ch4Sample,
   output logic outValid,
   output logic signed [23:0] ch4Trimmed,
   output logic signed [23:0] pairSample,
   output logic [1:0] decimationResponseSel,
   output logic [1:0] summationModeSel,
   output logic [1:0] highpassSel
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic awHeld;
      logic [11:0] awAddr;
      logic wHeld;
      logic [7:0] wByte;
      logic wLane;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [3:0] gainCode;
      logic [7:0] phaseCode;
      logic [7:0] dspCfg;
      logic [7:0] divCnt;
      logic modEn;
      logic outValid;
      logic signed [23:0] ch4Trim;
      logic signed [23:0] pairOut;
   } ctdc_top_state_t;

   ctdc_top_state_t q_reg;
   ctdc_top_state_t q_next;
   ctdc_pkg::ctdc_sel_t wrSel;
   ctdc_pkg::ctdc_sel_t rdSel;
   logic wrFire;
   logic signed [41:0] prod;
   logic signed [26:0] scaled;
   logic signed [24:0] pairSum;

   ctdc_delay_if dl();

   // Next-state logic: divider, bus slave, sample path
   always_comb begin
      q_next = q_reg;
      prod = ch4Sample * $signed({1'b0, ctdc_pkg::GAIN_LUT[q_reg.gainCode]});
      scaled = prod[41:15];
      pairSum = ch1Sample + ch2Sample;
      rdSel = ctdc_pkg::decodeAddr(s_axi_araddr);
      // Modulator clock enable
      q_next.modEn = 1'b0;
      if (q_reg.divCnt == 8'(MOD_DIV - 1)) begin
         q_next.divCnt = 8'h00;
         q_next.modEn = 1'b1;
      end else begin
         q_next.divCnt = q_reg.divCnt + 8'h01;
      end
      // Write address and data taken in either order
      if (s_axi_awvalid && q_reg.awready) begin
         q_next.awHeld = 1'b1;
         q_next.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q_reg.wready) begin
         q_next.wHeld = 1'b1;
         q_next.wByte = s_axi_wdata[7:0];
         q_next.wLane = s_axi_wstrb[0];
      end
      if (q_reg.bvalid && s_axi_bready) begin
         q_next.bvalid = 1'b0;
      end
      wrSel = ctdc_pkg::decodeAddr(q_next.awAddr);
      wrFire = q_next.awHeld && q_next.wHeld && !q_next.bvalid;
      if (wrFire) begin
         q_next.awHeld = 1'b0;
         q_next.wHeld = 1'b0;
         q_next.bvalid = 1'b1;
         q_next.bresp = (wrSel == ctdc_pkg::SEL_NONE) ?
            ctdc_pkg::RESP_SLVERR : ctdc_pkg::RESP_OKAY;
         if (q_next.wLane) begin
            if (wrSel == ctdc_pkg::SEL_GAIN) begin
               // Low nibble is not stored
               q_next.gainCode =
                  q_next.wByte[ctdc_pkg::GAIN_CODE_LSB +: 4];
            end else if (wrSel == ctdc_pkg::SEL_PHASE) begin
               q_next.phaseCode = q_next.wByte;
            end else if (wrSel == ctdc_pkg::SEL_DSP) begin
               q_next.dspCfg = q_next.wByte;
            end
         end
      end
      q_next.awready = !q_next.awHeld;
      q_next.wready = !q_next.wHeld;
      // Read channel, one read outstanding
      if (q_reg.rvalid && s_axi_rready) begin
         q_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q_reg.arready) begin
         q_next.rvalid = 1'b1;
         q_next.rresp = ctdc_pkg::RESP_OKAY;
         q_next.rdata = 32'h0;
         if (rdSel == ctdc_pkg::SEL_GAIN) begin
            q_next.rdata = {24'h0, q_reg.gainCode, 4'h0};
         end else if (rdSel == ctdc_pkg::SEL_PHASE) begin
            q_next.rdata = {24'h0, q_reg.phaseCode};
         end else if (rdSel == ctdc_pkg::SEL_DSP) begin
            q_next.rdata = {24'h0, q_reg.dspCfg};
         end else begin
            q_next.rresp = ctdc_pkg::RESP_SLVERR;
         end
      end
      q_next.arready = !q_next.rvalid;
      // Gain trim on channel 4, saturating, and channel pair average
      q_next.outValid = sampleValid;
      if (sampleValid) begin
         if (scaled > 27'sh07fffff) begin
            q_next.ch4Trim = 24'sh7fffff;
         end else if (scaled < 27'sh7800000) begin
            q_next.ch4Trim = 24'sh800000;
         end else begin
            q_next.ch4Trim = scaled[23:0];
         end
         if (q_reg.dspCfg[ctdc_pkg::SUM_LSB +: 2] == ctdc_pkg::SUM_AVG12) begin
            q_next.pairOut = pairSum[24:1];
         end else begin
            q_next.pairOut = ch1Sample;
         end
      end
   end

   // State register with documented reset values
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q_reg <= '0;
         q_reg.awready <= 1'b1;
         q_reg.wready <= 1'b1;
         q_reg.arready <= 1'b1;
         q_reg.gainCode <= ctdc_pkg::GAIN_TRIM_RST[7:4];
         q_reg.phaseCode <= ctdc_pkg::PHASE_TRIM_RST;
         q_reg.dspCfg <= ctdc_pkg::PATH_CFG0_RST;
      end else begin
         q_reg <= q_next;
      end
   end

   ctdc_phase_delay #(
      .DEPTH(ctdc_pkg::PHASE_DEPTH)
   ) u_delay (
      .clk(clk),
      .sys_rst(sys_rst),
      .dl(dl)
   );

   // Delay line feed and outputs
   assign dl.modEn = q_reg.modEn;
   assign dl.code = q_reg.phaseCode;
   assign dl.bitIn = pdmCh4In;
   assign ch4PdmDelayed = dl.bitOut;
   assign modClkEn = q_reg.modEn;
   assign s_axi_awready = q_reg.awready;
   assign s_axi_wready = q_reg.wready;
   assign s_axi_bvalid = q_reg.bvalid;
   assign s_axi_bresp = q_reg.bresp;
   assign s_axi_arready = q_reg.arready;
   assign s_axi_rvalid = q_reg.rvalid;
   assign s_axi_rdata = q_reg.rdata;
   assign s_axi_rresp = q_reg.rresp;
   assign outValid = q_reg.outValid;
   assign ch4Trimmed = q_reg.ch4Trim;
   assign pairSample = q_reg.pairOut;
   assign decimationResponseSel = q_reg.dspCfg[ctdc_pkg::DECI_LSB +: 2];
   assign summationModeSel = q_reg.dspCfg[ctdc_pkg::SUM_LSB +: 2];
   assign highpassSel = q_reg.dspCfg[ctdc_pkg::HPF_LSB +: 2];

   property p_gain_write;
      @(posedge clk) disable iff (sys_rst)
      wrFire && q_next.wLane && wrSel == ctdc_pkg::SEL_GAIN
         |=> q_reg.gainCode == $past(q_next.wByte[7:4]);
   endproperty
   a_gain_write: assert property (p_gain_write)
      else $error("gain code not written");

   property p_gain_read;
      @(posedge clk) disable iff (sys_rst)
      s_axi_arvalid && q_reg.arready && rdSel == ctdc_pkg::SEL_GAIN
         |=> s_axi_rvalid && s_axi_rdata[3:0] == 4'h0
            && s_axi_rdata[7:4] == $past(q_reg.gainCode);
   endproperty
   a_gain_read: assert property (p_gain_read)
      else $error("gain trim read wrong");

   property p_unity_gain;
      @(posedge clk) disable iff (sys_rst)
      sampleValid && q_reg.gainCode == ctdc_pkg::GAIN_UNITY_CODE
         |=> outValid && ch4Trimmed == $past(ch4Sample);
   endproperty
   a_unity_gain: assert property (p_unity_gain)
      else $error("unity gain changed the sample");

   property p_phase_write;
      @(posedge clk) disable iff (sys_rst)
      wrFire && q_next.wLane && wrSel == ctdc_pkg::SEL_PHASE
         |=> dl.code == $past(q_next.wByte);
   endproperty
   a_phase_write: assert property (p_phase_write)
      else $error("phase code not written");

   property p_read_upper_zero;
      @(posedge clk) disable iff (sys_rst)
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_read_upper_zero: assert property (p_read_upper_zero)
      else $error("upper read bits not zero");

   property p_pair_avg;
      @(posedge clk) disable iff (sys_rst)
      sampleValid && summationModeSel == ctdc_pkg::SUM_AVG12
         |=> pairSample == 24'((25'($past(ch1Sample))
            + 25'($past(ch2Sample))) >>> 1);
   endproperty
   a_pair_avg: assert property (p_pair_avg)
      else $error("pair average wrong");
endmodule

//--- bench/testbench.sv
// Self-checking bench for the channel 4 trim and config registers
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] awAddr = 12'h000;
   logic [11:0] arAddr = 12'h000;
   logic [31:0] wData = 32'h00000000;
   logic [3:0] wStrb = 4'h0;
   logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
   logic arValid = 1'b0, rReady = 1'b0;
   logic awReady, wReady, bValid, arReady, rValid;
   logic [1:0] bResp, rResp, decSel, sumSel, hpSel;
   logic [31:0] rData;
   logic pdmIn = 1'b0, sampleValid = 1'b0, pdmOut, modEn, outValid;
   logic signed [23:0] ch1 = 24'h000000, ch2 = 24'h000000;
   logic signed [23:0] ch4 = 24'h000000, trimOut, pairOut;
   logic hist [512];
   int fails = 0, cmpCount = 0;

   ctdc_trim_top #(.MOD_DIV(4)) uut (.clk(clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady), .pdmCh4In(pdmIn),
      .ch4PdmDelayed(pdmOut), .modClkEn(modEn), .sampleValid(sampleValid),
      .ch1Sample(ch1), .ch2Sample(ch2), .ch4Sample(ch4),
      .outValid(outValid), .ch4Trimmed(trimOut), .pairSample(pairOut),
      .decimationResponseSel(decSel), .summationModeSel(sumSel),
      .highpassSel(hpSel));

   // Clock at 200 MHz
   initial begin
      forever #2.5 clk = ~clk;
   end

   // Compare and count
   task automatic check(input string name, input logic [31:0] seen,
         input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // AXI4-Lite write, address and data offered together
   task automatic axWrite(input logic [11:0] a, input logic [7:0] d,
         input logic [3:0] s, input logic [1:0] expR);
      int n;
      @(posedge clk);
      awAddr <= a;
      wData <= {24'h000000, d};
      wStrb <= s;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (awValid && awReady) awValid <= 1'b0;
         if (wValid && wReady) wValid <= 1'b0;
         if (bValid === 1'b1) break;
      end
      bReady <= 1'b0;
      if (n == 100) fails++;
      check("bresp", {30'h0, bResp}, {30'h0, expR});
   endtask

   // AXI4-Lite read with data and response compare
   task automatic axRead(input logic [11:0] a, input logic [31:0] expD,
         input logic [1:0] expR);
      int n;
      @(posedge clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (arValid && arReady) arValid <= 1'b0;
         if (rValid === 1'b1) break;
      end
      rReady <= 1'b0;
      if (n == 100) fails++;
      check("rdata", rData, expD);
      check("rresp", {30'h0, rResp}, {30'h0, expR});
   endtask

   // Expected trimmed sample, floor shift and saturation
   function automatic logic [23:0] trimExp(input logic signed [23:0] x,
         input logic [3:0] g);
      logic signed [47:0] p;
      p = x * $signed({1'b0, ctdc_pkg::GAIN_LUT[g]});
      p = p >>> 15;
      if (p > 48'sh7fffff) return 24'h7fffff;
      if (p < -48'sh800000) return 24'h800000;
      return p[23:0];
   endfunction

   // One sample through the trim and pair path
   task automatic sendSample(input logic [23:0] a, input logic [23:0] b,
         input logic [23:0] c, input logic [23:0] eT, input logic [23:0] eP);
      @(posedge clk);
      ch1 <= a;
      ch2 <= b;
      ch4 <= c;
      sampleValid <= 1'b1;
      @(posedge clk);
      sampleValid <= 1'b0;
      #1;
      check("outValid", {31'h0, outValid}, 32'h1);
      check("ch4Trimmed", {8'h00, trimOut}, {8'h00, eT});
      check("pairSample", {8'h00, pairOut}, {8'h00, eP});
      @(posedge clk);
      #1;
      check("outValid", {31'h0, outValid}, 32'h0);
   endtask

   // PDM bits at modulator pulses, delayed output against history
   task automatic pdmRun(input int code);
      int n, k;
      for (n = 0; n < code + 24; n++) begin
         k = 0;
         do begin
            @(negedge clk);
            k++;
         end while (modEn !== 1'b1 && k < 20);
         if (k >= 20) fails++;
         // Divider set to 4 at the instance: one pulse every 4 clocks
         if (n > 0) check("modEn gap", k, 32'h4);
         hist[n] = pdmIn;
         @(posedge clk);
         pdmIn <= n[1] ^ n[4] ^ (n[0] & n[2]);
         #1;
         if (n >= code) check("pdm", {31'h0, pdmOut}, {31'h0, hist[n - code]});
      end
   endtask

   // Main sequence
   initial begin
      int i;
      logic [1:0] c;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      check("decSel", {30'h0, decSel}, 32'h0);
      check("sumSel", {30'h0, sumSel}, 32'h0);
      check("hpSel", {30'h0, hpSel}, 32'h1);
      axRead(ctdc_pkg::GAIN_TRIM_ADDR, 32'h80, ctdc_pkg::RESP_OKAY);
      axRead(ctdc_pkg::PHASE_TRIM_ADDR, 32'h00, ctdc_pkg::RESP_OKAY);
      axRead(ctdc_pkg::PATH_CFG0_ADDR, 32'h01, ctdc_pkg::RESP_OKAY);
      // Software keeps the reserved low nibble at zero
      axWrite(ctdc_pkg::GAIN_TRIM_ADDR, 8'hf0, 4'h1,
         ctdc_pkg::RESP_OKAY);
      axRead(ctdc_pkg::GAIN_TRIM_ADDR, 32'hf0, ctdc_pkg::RESP_OKAY);
      axWrite(12'h140, 8'h55, 4'h1, ctdc_pkg::RESP_SLVERR);
      axRead(12'h140, 32'h00, ctdc_pkg::RESP_SLVERR);
      axWrite(ctdc_pkg::PHASE_TRIM_ADDR, 8'h5a, 4'h0, ctdc_pkg::RESP_OKAY);
      axRead(ctdc_pkg::PHASE_TRIM_ADDR, 32'h00, ctdc_pkg::RESP_OKAY);
      // Every code of every config field
      for (i = 0; i < 4; i++) begin
         c = i[1:0];
         axWrite(ctdc_pkg::PATH_CFG0_ADDR, {c, c, c, c}, 4'h1, 2'h0);
         axRead(ctdc_pkg::PATH_CFG0_ADDR, {24'h0, c, c, c, c}, 2'h0);
         check("decSel", {30'h0, decSel}, {30'h0, c});
         check("sumSel", {30'h0, sumSel}, {30'h0, c});
         check("hpSel", {30'h0, hpSel}, {30'h0, c});
      end
      // Every gain code with channel 1 and 2 averaging
      axWrite(ctdc_pkg::PATH_CFG0_ADDR, 8'h04, 4'h1, ctdc_pkg::RESP_OKAY);
      for (i = 0; i < 16; i++) begin
         axWrite(ctdc_pkg::GAIN_TRIM_ADDR, {i[3:0], 4'h0}, 4'h1, 2'h0);
         sendSample(24'h200000, 24'hcfffff, 24'h9abcdf,
            trimExp(24'h9abcdf, i[3:0]), 24'hf7ffff);
      end
      sendSample(24'h200000, 24'hcfffff, 24'h7fffff, 24'h7fffff,
         24'hf7ffff);
      axWrite(ctdc_pkg::PATH_CFG0_ADDR, 8'h01, 4'h1, ctdc_pkg::RESP_OKAY);
      axWrite(ctdc_pkg::GAIN_TRIM_ADDR, 8'h80, 4'h1, ctdc_pkg::RESP_OKAY);
      sendSample(24'h200000, 24'hcfffff, 24'h9abcdf, 24'h9abcdf,
         24'h200000);
      // Phase delay at both ends of the code range
      for (i = 0; i < 4; i++) begin
         c = i[1:0];
         axWrite(ctdc_pkg::PHASE_TRIM_ADDR, (c == 2'h3) ? 8'hff : {6'h0, c},
            4'h1, ctdc_pkg::RESP_OKAY);
         pdmRun((c == 2'h3) ? 255 : i);
      end
      axRead(ctdc_pkg::PHASE_TRIM_ADDR, 32'hff, ctdc_pkg::RESP_OKAY);
      // Reset in mid-run restores defaults
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      axRead(ctdc_pkg::GAIN_TRIM_ADDR, 32'h80, ctdc_pkg::RESP_OKAY);
      axRead(ctdc_pkg::PHASE_TRIM_ADDR, 32'h00, ctdc_pkg::RESP_OKAY);
      axRead(ctdc_pkg::PATH_CFG0_ADDR, 32'h01, ctdc_pkg::RESP_OKAY);
      final_report();
   end

   // Watchdog against a hang
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      final_report();
   end
endmodule
